//--- common/iec_consts.vh
`ifndef IEC_CONSTS_VH
`define IEC_CONSTS_VH

// Register byte offsets
`define IEC_OFS_CTRL 8'h6c
`define IEC_OFS_STATUS 8'h70
`define IEC_OFS_INT_STAT 8'h80
`define IEC_OFS_INT_MASK 8'h84

// Control register fields
`define IEC_CTRL_EN 0
`define IEC_CTRL_ABORT 1
`define IEC_CTRL_HOLD 2
`define IEC_CTRL_RESET 3'h0

// Status register fields
`define IEC_ST_ACT 0
`define IEC_ST_TFNF 1
`define IEC_ST_TFE 2
`define IEC_ST_RFNE 3
`define IEC_ST_MST 5

// Interrupt status fields
`define IEC_INT_ABORT 0
`define IEC_INT_STOP 1
`define IEC_INT_START 2
`define IEC_INT_W 3

// Clock relation: 1 means core clock asynchronous to bus clock
`define IEC_CLK_ASYNC 1
`define IEC_HOLD_DEFAULT 1'b0

// STOP setup time, least time so rounded up
`define IEC_CLK_NS 10
`define IEC_STOP_NS 4000
`define IEC_STOP_CYC ((`IEC_STOP_NS + `IEC_CLK_NS - 1) / `IEC_CLK_NS)

`endif

//--- rtl/iec_sync.v
// Two-flop synchroniser for pin inputs
module iec_sync #(
  parameter W = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage only feeds the second
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // iec_sync

//--- rtl/iec_top.v
`include "iec_consts.vh"

module iec_top #(
  parameter clock_relation_param = `IEC_CLK_ASYNC,
  parameter command_hold_default_param = `IEC_HOLD_DEFAULT
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg irq_r,
  input wire master_mode,
  input wire tx_fifo_empty,
  input wire tx_fifo_full,
  input wire rx_fifo_not_empty,
  input wire xfer_busy,
  input wire xfer_rx,
  output reg core_en_r,
  output reg core_go_r,
  output reg core_end_r,
  output reg rx_nack_r,
  output reg tx_flush_r,
  output reg rx_flush_r,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r
);
  // Abort sequencer states
  localparam [2:0] AB_IDLE = 3'h0;
  localparam [2:0] AB_WAIT = 3'h1;
  localparam [2:0] AB_SCLLO = 3'h2;
  localparam [2:0] AB_SCLHI = 3'h3;
  localparam [2:0] AB_DONE = 3'h4;
  // Full-width copy first so the cut to the counter width is deliberate
  localparam [31:0] STOP_CYC_W = `IEC_STOP_CYC;
  localparam [8:0] STOP_CYC = STOP_CYC_W[8:0];

  reg en_r;
  reg abort_r;
  reg hold_r;
  reg [1:0] en_pipe_r;
  reg [2:0] ab_st_r;
  reg [2:0] ab_st_nxt;
  reg [8:0] stop_cnt_r;
  reg [`IEC_INT_W-1:0] int_stat_r;
  reg [`IEC_INT_W-1:0] int_mask_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [31:0] rd_val;
  reg [`IEC_INT_W-1:0] int_set;
  wire [1:0] pins_s;
  wire scl_s;
  wire sda_s;
  wire en_eff;
  wire addr_ok;
  wire ctrl_wr;
  wire stop_seen;
  wire start_seen;
  wire busy_any;
  wire idle_now;

  // Bus pins cross into the core clock domain
  iec_sync #(.W(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous pin levels for edge detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // SDA edges while SCL stays high mark bus conditions
  assign stop_seen = scl_s && scl_d_r && sda_s && !sda_d_r;
  assign start_seen = scl_s && scl_d_r && !sda_s && sda_d_r;

  // Enable reaches the core two cycles late in asynchronous mode
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_pipe_r <= 2'h0;
    end else begin
      en_pipe_r <= {en_pipe_r[0], en_r};
    end
  end
  assign en_eff = (clock_relation_param == 1) ? en_pipe_r[1] : en_r;

  assign busy_any = xfer_busy || (ab_st_r != AB_IDLE);
  assign idle_now = !busy_any;

  // AHB-Lite address phase capture
  assign addr_ok = hsel && htrans[1] && hready;
  assign ctrl_wr = wr_pend_r && (wr_addr_r == `IEC_OFS_CTRL);

  // Read mux; status overrides FIFO flags while disabled
  always @* begin
    rd_val = 32'h0;
    case (haddr[7:0])
      `IEC_OFS_CTRL: begin
        rd_val[`IEC_CTRL_EN] = en_r;
        rd_val[`IEC_CTRL_ABORT] = abort_r;
        rd_val[`IEC_CTRL_HOLD] = hold_r;
      end
      `IEC_OFS_STATUS: begin
        rd_val[`IEC_ST_ACT] = busy_any;
        rd_val[`IEC_ST_TFNF] = !en_eff || !tx_fifo_full;
        rd_val[`IEC_ST_TFE] = !en_eff || tx_fifo_empty;
        rd_val[`IEC_ST_RFNE] = en_eff && rx_fifo_not_empty;
        rd_val[`IEC_ST_MST] = busy_any && master_mode;
      end
      `IEC_OFS_INT_STAT: begin
        rd_val[`IEC_INT_W-1:0] = int_stat_r & int_mask_r;
      end
      `IEC_OFS_INT_MASK: begin
        rd_val[`IEC_INT_W-1:0] = int_mask_r;
      end
      default: begin
        rd_val = 32'h0;
      end
    endcase
  end

  // Slave answers with no wait states; read data sampled at address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // Control register: enable, abort (set only), command hold
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
      abort_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        en_r <= hwdata[`IEC_CTRL_EN];
        hold_r <= hwdata[`IEC_CTRL_HOLD];
      end
      // Hardware clear on completion; a zero write never clears
      if (ab_st_r == AB_DONE) begin
        abort_r <= 1'b0;
      end else if (ctrl_wr && hwdata[`IEC_CTRL_ABORT] && en_r && master_mode) begin
        abort_r <= 1'b1;
      end
    end
  end

  // Hold is honoured only from the first cycle after reset release, not under it
  reg hold_init_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_init_r <= 1'b0;
    end else begin
      hold_init_r <= 1'b1;
    end
  end

  // Abort sequencer next state
  always @* begin
    ab_st_nxt = ab_st_r;
    case (ab_st_r)
      AB_IDLE: begin
        if (abort_r) begin
          ab_st_nxt = AB_WAIT;
        end
      end
      AB_WAIT: begin
        if (!xfer_busy) begin
          ab_st_nxt = AB_SCLLO;
        end
      end
      AB_SCLLO: begin
        if (!scl_s) begin
          ab_st_nxt = AB_SCLHI;
        end
      end
      AB_SCLHI: begin
        if (scl_s && stop_cnt_r == STOP_CYC) begin
          ab_st_nxt = AB_DONE;
        end
      end
      AB_DONE: begin
        ab_st_nxt = AB_IDLE;
      end
      default: begin
        ab_st_nxt = AB_IDLE;
      end
    endcase
  end

  // Sequencer, STOP setup counter and SDA drive
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ab_st_r <= AB_IDLE;
      stop_cnt_r <= 9'h0;
      sda_out_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      ab_st_r <= ab_st_nxt;
      sda_out_r <= 1'b0;
      if (ab_st_r == AB_SCLHI && scl_s && stop_cnt_r != STOP_CYC) begin
        stop_cnt_r <= stop_cnt_r + 9'h1;
      end else if (ab_st_r != AB_SCLHI) begin
        stop_cnt_r <= 9'h0;
      end
      // SDA pulled low from SCL low through the SCL-high setup count, then released: STOP
      if (ab_st_nxt == AB_SCLHI) begin
        sda_oe_r <= 1'b1;
      end else begin
        sda_oe_r <= 1'b0;
      end
    end
  end

  // Interrupt events; set wins over a same-cycle clear
  always @* begin
    int_set = {`IEC_INT_W{1'b0}};
    int_set[`IEC_INT_ABORT] = (ab_st_r == AB_DONE);
    int_set[`IEC_INT_STOP] = stop_seen;
    int_set[`IEC_INT_START] = start_seen;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_r <= {`IEC_INT_W{1'b0}};
      int_mask_r <= {`IEC_INT_W{1'b0}};
    end else begin
      if (wr_pend_r && wr_addr_r == `IEC_OFS_INT_MASK) begin
        int_mask_r <= hwdata[`IEC_INT_W-1:0];
      end
      // Flags survive disable until the controller reaches idle
      if (!en_eff && idle_now) begin
        int_stat_r <= int_set;
      end else if (wr_pend_r && wr_addr_r == `IEC_OFS_INT_STAT) begin
        int_stat_r <= (int_stat_r & ~hwdata[`IEC_INT_W-1:0]) | int_set;
      end else begin
        int_stat_r <= int_stat_r | int_set;
      end
    end
  end

  // Core controls, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_en_r <= 1'b0;
      core_go_r <= 1'b0;
      core_end_r <= 1'b0;
      rx_nack_r <= 1'b0;
      tx_flush_r <= 1'b1;
      rx_flush_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      core_en_r <= en_eff;
      // Start only with work queued, no hold and no abort
      core_go_r <= en_eff && master_mode && !(hold_r && hold_init_r) && !tx_fifo_empty
        && (ab_st_r == AB_IDLE) && !abort_r;
      // Disabled mid-transfer: finish current transfer, then stop
      core_end_r <= (!en_eff && xfer_busy) || (ab_st_r == AB_WAIT);
      // Receiving when disabled: no acknowledge on the current byte
      rx_nack_r <= !en_eff && xfer_busy && xfer_rx;
      // FIFOs held flushed while disabled; discard waits for transfer end
      tx_flush_r <= (!en_eff && !xfer_busy) || (ab_st_r == AB_DONE);
      rx_flush_r <= !en_eff && !xfer_busy;
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end
endmodule // iec_top

//--- tb/iec_bus_model.sv
module iec_bus_model (
  input wire logic run,
  input wire logic sda_oe_r,
  input wire logic sda_out_r,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock toggles only within frames; held high once SDA is pulled so STOP can form
  initial begin
    scl = 1'b1;
    #3;
    forever #40 scl = (run && !sda_oe_r) ? !scl : 1'b1;
  end
  // Pull-up: released line reads high
  assign sda = !(sda_oe_r && !sda_out_r);
endmodule // iec_bus_model

//--- tb/iec_top_props.sv
`include "iec_consts.vh"

module iec_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hresp,
  input wire master_mode,
  input wire tx_fifo_empty,
  input wire xfer_busy,
  input wire xfer_rx,
  input wire core_en_r,
  input wire core_go_r,
  input wire core_end_r,
  input wire rx_nack_r,
  input wire tx_flush_r,
  input wire rx_flush_r,
  input wire sda_oe_r
);
  localparam int stop_cyc = `IEC_STOP_CYC;
  logic wr_ph_r, hold_r, en_r;
  int oe_cnt_r;
  // Shadow of control writes, taken at the edge the slave commits them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      hold_r <= 1'b0;
      en_r <= 1'b0;
      oe_cnt_r <= 0;
    end else begin
      if (hready)
        wr_ph_r <= hsel && htrans[1] && hwrite && haddr[7:0] == `IEC_OFS_CTRL;
      if (wr_ph_r && hready) begin
        hold_r <= hwdata[`IEC_CTRL_HOLD];
        en_r <= hwdata[`IEC_CTRL_EN];
      end
      oe_cnt_r <= sda_oe_r ? oe_cnt_r + 1 : 0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_hold_blocks: assert property (hold_r && $past(hold_r) && master_mode |-> !core_go_r)
    else $error("start while held");
  chk_go_starts:
    assert property ((core_en_r && !hold_r && master_mode && !tx_fifo_empty && !xfer_busy && !core_end_r) [*3]
      |-> core_go_r) else $error("no start");
  // Flush waits for a running transfer to finish, so only idle cycles count
  chk_off_flush: assert property (!core_en_r && !$past(core_en_r) && !$past(xfer_busy)
    |-> tx_flush_r && rx_flush_r) else $error("fifo not flushed");
  chk_en_delay: assert property ($changed(en_r) |-> ##[2:3] core_en_r == en_r)
    else $error("enable late");
  chk_stop_len: assert property ($fell(sda_oe_r) |-> oe_cnt_r >= stop_cyc)
    else $error("stop too short");
  chk_abort_flush: assert property ($fell(sda_oe_r) |-> ##[0:2] tx_flush_r)
    else $error("no flush");
  chk_stop_idle: assert property ($rose(sda_oe_r) |-> !xfer_busy)
    else $error("stop mid transfer");
  chk_tx_end: assert property (!core_en_r && xfer_busy && !xfer_rx |-> ##[0:2] core_end_r)
    else $error("no end");
  chk_rx_nack: assert property (!core_en_r && xfer_busy && xfer_rx |-> ##[0:2] rx_nack_r)
    else $error("no nack");
  chk_resp_okay: assert property (!hresp)
    else $error("error response");
  cover property ($fell(sda_oe_r));
  cover property (hold_r && master_mode && !tx_fifo_empty);
  cover property (!core_en_r && xfer_busy && xfer_rx);
endmodule // iec_chk

bind iec_top iec_chk i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hresp(hresp), .master_mode(master_mode), .tx_fifo_empty(tx_fifo_empty),
  .xfer_busy(xfer_busy), .xfer_rx(xfer_rx), .core_en_r(core_en_r), .core_go_r(core_go_r),
  .core_end_r(core_end_r), .rx_nack_r(rx_nack_r), .tx_flush_r(tx_flush_r), .rx_flush_r(rx_flush_r),
  .sda_oe_r(sda_oe_r)
);

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, run = 1'b0;
  logic master_mode = 1'b0, tx_fifo_empty = 1'b1, tx_fifo_full = 1'b0, rx_fifo_not_empty = 1'b0;
  logic xfer_busy = 1'b0, xfer_rx = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, irq_r, core_en_r, core_go_r, core_end_r, rx_nack_r, tx_flush_r, rx_flush_r;
  logic scl, sda, sda_out_r, sda_oe_r;
  logic [31:0] exp_q[$];
  int fails = 0, samples_checked = 0, seed = 31, cyc = 0;

  iec_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq_r(irq_r), .master_mode(master_mode), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_full(tx_fifo_full), .rx_fifo_not_empty(rx_fifo_not_empty), .xfer_busy(xfer_busy),
    .xfer_rx(xfer_rx), .core_en_r(core_en_r), .core_go_r(core_go_r), .core_end_r(core_end_r),
    .rx_nack_r(rx_nack_r), .tx_flush_r(tx_flush_r), .rx_flush_r(rx_flush_r), .scl_in(scl),
    .sda_in(sda), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r)
  );
  iec_bus_model i_bus (.run(run), .sda_oe_r(sda_oe_r), .sda_out_r(sda_out_r), .scl(scl), .sda(sda));

  // Core clock
  initial forever #5 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, wrong %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Single transfer; each phase held until hready is seen high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic wait_for(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++)
      @(posedge hclk);
  endtask

  // Read data taken at the edge that closes the data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout && exp_q.size() > 0)
      chk(hrdata, exp_q.pop_front());
  end

  // Random FIFO levels: status must hide them while off; hang cut short
  always @(posedge hclk) begin
    tx_fifo_full <= 1'($random(seed));
    rx_fifo_not_empty <= 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] d;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h6c, 32'h0);
    rd(8'h70, 32'h6);
    d = $random(seed);
    xfer(8'h6c, 1'b1, {d[31:3], 3'b010});
    rd(8'h6c, 32'h0);
    rd(8'h94, 32'h0);
    // Hold set while idle and empty, then commands queued
    master_mode <= 1'b1;
    xfer(8'h6c, 1'b1, 32'h5);
    rd(8'h6c, 32'h5);
    tx_fifo_empty <= 1'b0;
    repeat (10) @(posedge hclk);
    chk({31'h0, core_go_r}, 32'h0);
    xfer(8'h6c, 1'b1, 32'h1);
    wait_for(core_go_r, 8);
    chk({31'h0, core_go_r}, 32'h1);
    // Disable mid transfer: end requested, flush only once the transfer is over
    xfer_busy <= 1'b1;
    xfer(8'h6c, 1'b1, 32'h0);
    wait_for(core_end_r, 8);
    chk({29'h0, core_end_r, tx_flush_r, rx_flush_r}, 32'h4);
    xfer_rx <= 1'b1;
    wait_for(rx_nack_r, 4);
    chk({31'h0, rx_nack_r}, 32'h1);
    xfer_busy <= 1'b0;
    xfer_rx <= 1'b0;
    tx_fifo_empty <= 1'b1;
    wait_for(tx_flush_r, 8);
    chk({29'h0, core_end_r, tx_flush_r, rx_flush_r}, 32'h3);
    // Abort with a transfer running; a zero write must not cancel it
    xfer(8'h84, 1'b1, 32'h1);
    xfer(8'h6c, 1'b1, 32'h1);
    repeat (4) @(posedge hclk);
    xfer_busy <= 1'b1;
    run <= 1'b1;
    xfer(8'h6c, 1'b1, 32'h3);
    xfer(8'h6c, 1'b1, 32'h1);
    rd(8'h6c, 32'h3);
    xfer_busy <= 1'b0;
    wait_for(irq_r, 1000);
    chk({31'h0, irq_r}, 32'h1);
    run <= 1'b0;
    rd(8'h6c, 32'h1);
    rd(8'h80, 32'h1);
    xfer(8'h80, 1'b1, 32'h1);
    rd(8'h80, 32'h0);
    chk({31'h0, irq_r}, 32'h0);
    end_of_test();
  end
endmodule // tb_top
